// ### verilog/hfc_clock_request_control.sv
// Fast clock request controller: per-core request gathering, shared source
// sequencing with glitch-free source change, start tasks and wake latencies.
// Assumes all inputs are synchronous to clk_sys and tasks are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module hfc_clock_request_control #(
  parameter int NUM_CORES = 2,          // Cores with a local controller
  parameter int REQS_PER_CORE = 4,      // Requesters inside each core
  parameter int INT_START_CYCLES = 8,   // Internal oscillator settle time
  parameter int XO_START_CYCLES = 20    // Crystal power-up plus count time
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic systemOn,
  input wire logic [NUM_CORES*REQS_PER_CORE-1:0] coreRequests,
  input wire logic [NUM_CORES-1:0] fastClockStartTask,
  input wire logic [NUM_CORES-1:0] fastClockStopTask,
  input wire logic [NUM_CORES-1:0] fastSourceSelect,
  input wire logic keepRunning,
  input wire logic audioStartTask,
  input wire logic audioStopTask,
  input wire logic audioInUse,
  input wire logic audioBandHigh,
  input wire logic [NUM_CORES-1:0] irqEnableShared,
  input wire logic appIdleExit,
  input wire logic appConstLatency,
  input wire logic netIdleExit,
  input wire logic netConstLatency,
  input wire logic netCoreForceOff,
  input wire logic offWakeup,
  input wire logic [NUM_CORES-1:0] hwEvent,
  output logic [NUM_CORES-1:0] coreClockRequest,
  output logic [NUM_CORES-1:0] fastClockStartedEvent,
  output logic [NUM_CORES-1:0] startedIrq,
  output logic fastClockRunning,
  output logic fastClockOnCrystal,
  output logic internalOscOn,
  output logic crystalOscOn,
  output logic appCpuClockEn,
  output logic netCpuClockEn,
  output logic flashIfClockEn,
  output logic usbClockEn,
  output logic periphClockHiEn,
  output logic periphClockMidEn,
  output logic periphClockLoEn,
  output logic audioClockEn,
  output logic audioRateHigh,
  output logic appCpuResume,
  output logic netCpuResume,
  output logic netCpuStart,
  output logic appCpuStart,
  output logic [NUM_CORES-1:0] interconnectEvent
);

  // Refuse shapes the logic cannot serve
  if (NUM_CORES < 2) begin : gChkCores
    $error("NUM_CORES must cover the application and network cores");
  end
  if (REQS_PER_CORE < 1) begin : gChkReqs
    $error("REQS_PER_CORE must be at least one");
  end
  if (INT_START_CYCLES < 1 || INT_START_CYCLES >= (1 << hfc_pkg::TIMER_W) ||
      XO_START_CYCLES < 1 || XO_START_CYCLES >= (1 << hfc_pkg::TIMER_W)) begin : gChkOsc
    $error("Oscillator start times must fit the start-up counter");
  end
  if (hfc_pkg::SRC_64_MHZ % hfc_pkg::PERIPH_MID_MHZ != 0 ||
      hfc_pkg::SRC_64_MHZ % hfc_pkg::PERIPH_LO_MHZ != 0) begin : gChkRates
    $error("Peripheral clocks must divide the 64 MHz source");
  end

  // Oscillator settle counts at counter width
  localparam logic [hfc_pkg::TIMER_W-1:0] INT_START_CNT = hfc_pkg::TIMER_W'(INT_START_CYCLES);
  localparam logic [hfc_pkg::TIMER_W-1:0] XO_START_CNT = hfc_pkg::TIMER_W'(XO_START_CYCLES);

  // Per-core request level, hold from start task, and crystal choice of hold
  logic [NUM_CORES-1:0] coreReq_q;
  logic [NUM_CORES-1:0] hold_q;
  logic [NUM_CORES-1:0] holdXo_q;
  // Pending started event and the source it waits for
  logic [NUM_CORES-1:0] pending_q;
  logic [NUM_CORES-1:0] pendXo_q;
  // Audio start hold
  logic audioHold_q;
  // Sequencer state, current source (1 = crystal) and settle counter
  hfc_pkg::hfc_osc_state_type state_q;
  logic src_q;
  logic [hfc_pkg::TIMER_W-1:0] oscCnt_q;
  // Previous force-off level, for release detection
  logic forceOffPrev_q;
  // Combined demand terms
  logic audioActive;
  logic needClock;
  logic wantXo;
  logic gateOpen;

  // Settle count for the given source
  function automatic logic [hfc_pkg::TIMER_W-1:0] startCount(input logic xo);
    return xo ? XO_START_CNT : INT_START_CNT;
  endfunction

  // Audio keeps running while held by its task or used by a peripheral
  assign audioActive = audioHold_q | audioInUse;
  // Demand reaches the source only in powered-on state
  assign needClock = systemOn & (|coreReq_q | |hold_q | keepRunning | audioActive);
  // Crystal only when a start task chose it or audio needs it
  assign wantXo = |(hold_q & holdXo_q) | audioActive;
  // Clock tree is fed only while the source is settled
  assign gateOpen = (state_q inside {hfc_pkg::OSC_RUN, hfc_pkg::OSC_SWITCH}) & systemOn;

  // Per-core request gathering
  for (genvar c = 0; c < NUM_CORES; c++) begin : gCore
    // Any local requester raises this core's request
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        coreReq_q[c] <= 1'b0;
      end else begin
        coreReq_q[c] <= |coreRequests[c*REQS_PER_CORE +: REQS_PER_CORE];
      end
    end

    // Start task holds the source; stop releases it, start wins a tie
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        hold_q[c] <= 1'b0;
        holdXo_q[c] <= 1'b0;
      end else if (fastClockStartTask[c]) begin
        hold_q[c] <= 1'b1;
        holdXo_q[c] <= fastSourceSelect[c];
      end else if (fastClockStopTask[c]) begin
        hold_q[c] <= 1'b0;
      end
    end

    // One started event per run of triggers, for the last trigger
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        pending_q[c] <= 1'b0;
        pendXo_q[c] <= 1'b0;
        fastClockStartedEvent[c] <= 1'b0;
        startedIrq[c] <= 1'b0;
      end else if (fastClockStartTask[c]) begin
        // Retrigger restarts the wait, no event this cycle
        pending_q[c] <= 1'b1;
        pendXo_q[c] <= fastSourceSelect[c];
        fastClockStartedEvent[c] <= 1'b0;
        startedIrq[c] <= 1'b0;
      end else if (pending_q[c] && gateOpen && (src_q || !pendXo_q[c])) begin
        // Settled on the chosen source or a more accurate one
        pending_q[c] <= 1'b0;
        fastClockStartedEvent[c] <= 1'b1;
        startedIrq[c] <= irqEnableShared[c];
      end else begin
        fastClockStartedEvent[c] <= 1'b0;
        startedIrq[c] <= 1'b0;
      end
    end

    // Hardware event forwarded to the interconnect one cycle later
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        interconnectEvent[c] <= 1'b0;
      end else begin
        interconnectEvent[c] <= hwEvent[c];
      end
    end
  end

  // Requests as seen by the shared subsystem
  assign coreClockRequest = coreReq_q;

  // Audio start hold, released by stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      audioHold_q <= 1'b0;
    end else if (audioStartTask) begin
      audioHold_q <= 1'b1;
    end else if (audioStopTask) begin
      audioHold_q <= 1'b0;
    end
  end

  // Shared source sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= hfc_pkg::OSC_OFF;
      src_q <= 1'b0;
      oscCnt_q <= '0;
    end else begin
      unique case (state_q)
        // Idle: start the wanted source on demand
        hfc_pkg::OSC_OFF: begin
          if (needClock) begin
            src_q <= wantXo;
            oscCnt_q <= startCount(wantXo);
            state_q <= hfc_pkg::OSC_START;
          end
        end
        // Settling: restart if the wanted source changes
        hfc_pkg::OSC_START: begin
          if (!needClock) begin
            state_q <= hfc_pkg::OSC_OFF;
          end else if (wantXo != src_q) begin
            src_q <= wantXo;
            oscCnt_q <= startCount(wantXo);
          end else if (oscCnt_q <= 1) begin
            oscCnt_q <= '0;
            state_q <= hfc_pkg::OSC_RUN;
          end else begin
            oscCnt_q <= oscCnt_q - 1'b1;
          end
        end
        // Running: watch for withdrawal or a source change
        hfc_pkg::OSC_RUN: begin
          if (!needClock) begin
            state_q <= hfc_pkg::OSC_OFF;
          end else if (wantXo != src_q) begin
            oscCnt_q <= startCount(wantXo);
            state_q <= hfc_pkg::OSC_SWITCH;
          end
        end
        // New source warms while the old one still feeds the tree
        hfc_pkg::OSC_SWITCH: begin
          if (!needClock) begin
            state_q <= hfc_pkg::OSC_OFF;
          end else if (wantXo == src_q) begin
            state_q <= hfc_pkg::OSC_RUN;
          end else if (oscCnt_q <= 1) begin
            // Gate closes and the source flips together
            oscCnt_q <= '0;
            src_q <= wantXo;
            state_q <= hfc_pkg::OSC_GATE;
          end else begin
            oscCnt_q <= oscCnt_q - 1'b1;
          end
        end
        // One dead cycle with the tree gated, then reopen, or go off if demand is gone
        hfc_pkg::OSC_GATE: begin
          state_q <= needClock ? hfc_pkg::OSC_RUN : hfc_pkg::OSC_OFF;
        end
      endcase
    end
  end

  // Source status flags; both oscillators run during a switch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fastClockRunning <= 1'b0;
      fastClockOnCrystal <= 1'b0;
      internalOscOn <= 1'b0;
      crystalOscOn <= 1'b0;
    end else begin
      fastClockRunning <= gateOpen;
      fastClockOnCrystal <= src_q;
      internalOscOn <= (state_q != hfc_pkg::OSC_OFF) &&
                       (!src_q || (state_q == hfc_pkg::OSC_SWITCH && !wantXo));
      crystalOscOn <= (state_q != hfc_pkg::OSC_OFF) &&
                      (src_q || (state_q == hfc_pkg::OSC_SWITCH && wantXo));
    end
  end

  // Core clock gates: application core clocks from the 128/192/64 sources
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      appCpuClockEn <= 1'b0;
      flashIfClockEn <= 1'b0;
      usbClockEn <= 1'b0;
      periphClockHiEn <= 1'b0;
      periphClockMidEn <= 1'b0;
      periphClockLoEn <= 1'b0;
    end else begin
      appCpuClockEn <= gateOpen & coreReq_q[hfc_pkg::CORE_APP];
      flashIfClockEn <= gateOpen & coreReq_q[hfc_pkg::CORE_APP];
      // USB needs crystal accuracy
      usbClockEn <= gateOpen & src_q & coreReq_q[hfc_pkg::CORE_APP];
      periphClockHiEn <= gateOpen & coreReq_q[hfc_pkg::CORE_APP];
      periphClockMidEn <= gateOpen & coreReq_q[hfc_pkg::CORE_APP];
      periphClockLoEn <= gateOpen & coreReq_q[hfc_pkg::CORE_APP];
    end
  end

  // Network core clock and audio clock gates
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      netCpuClockEn <= 1'b0;
      audioClockEn <= 1'b0;
      audioRateHigh <= 1'b0;
    end else begin
      netCpuClockEn <= gateOpen & coreReq_q[hfc_pkg::CORE_NET];
      // Audio clock only ever comes from the crystal
      audioClockEn <= gateOpen & src_q & audioActive;
      audioRateHigh <= audioBandHigh;
    end
  end

  // Force-off level history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      forceOffPrev_q <= 1'b1;
    end else begin
      forceOffPrev_q <= netCoreForceOff;
    end
  end

  // Wake latency timers: trigger, load value, count and pulse
  logic [hfc_pkg::TMR_COUNT-1:0] tmrTrig;
  logic [hfc_pkg::TIMER_W-1:0] tmrLoad [hfc_pkg::TMR_COUNT];
  logic [hfc_pkg::TIMER_W-1:0] tmrCnt_q [hfc_pkg::TMR_COUNT];
  logic [hfc_pkg::TMR_COUNT-1:0] tmrPulse_q;

  // Trigger sources and their latencies per mode
  always_comb begin
    tmrTrig[hfc_pkg::TMR_APP_IDLE] = appIdleExit;
    tmrLoad[hfc_pkg::TMR_APP_IDLE] = appConstLatency ? hfc_pkg::APP_IDLE_CONSTLAT_CYC
                                                     : hfc_pkg::APP_IDLE_NORMAL_CYC;
    tmrTrig[hfc_pkg::TMR_NET_IDLE] = netIdleExit;
    tmrLoad[hfc_pkg::TMR_NET_IDLE] = netConstLatency ? hfc_pkg::NET_IDLE_CONSTLAT_CYC
                                                     : hfc_pkg::NET_IDLE_NORMAL_CYC;
    tmrTrig[hfc_pkg::TMR_NET_START] = forceOffPrev_q & ~netCoreForceOff;
    tmrLoad[hfc_pkg::TMR_NET_START] = hfc_pkg::NET_FORCE_OFF_RELEASE_CYC;
    tmrTrig[hfc_pkg::TMR_APP_WAKE] = offWakeup;
    tmrLoad[hfc_pkg::TMR_APP_WAKE] = hfc_pkg::APP_OFF_WAKE_CYC;
  end

  // Each timer pulses exactly its load count of cycles after its trigger
  for (genvar t = 0; t < hfc_pkg::TMR_COUNT; t++) begin : gTimer
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        tmrCnt_q[t] <= '0;
        tmrPulse_q[t] <= 1'b0;
      end else if (tmrTrig[t]) begin
        // A new trigger restarts the wait
        tmrCnt_q[t] <= tmrLoad[t];
        tmrPulse_q[t] <= 1'b0;
      end else if (tmrCnt_q[t] == 1) begin
        tmrCnt_q[t] <= '0;
        tmrPulse_q[t] <= 1'b1;
      end else begin
        tmrCnt_q[t] <= (tmrCnt_q[t] == 0) ? tmrCnt_q[t] : tmrCnt_q[t] - 1'b1;
        tmrPulse_q[t] <= 1'b0;
      end
    end
  end

  // Wake pulses straight from the timer flip-flops
  assign appCpuResume = tmrPulse_q[hfc_pkg::TMR_APP_IDLE];
  assign netCpuResume = tmrPulse_q[hfc_pkg::TMR_NET_IDLE];
  assign netCpuStart = tmrPulse_q[hfc_pkg::TMR_NET_START];
  assign appCpuStart = tmrPulse_q[hfc_pkg::TMR_APP_WAKE];

endmodule // hfc_clock_request_control

`default_nettype wire

// ### verilog/hfc_pkg.sv
// Shared constants for the fast clock request controller.
// Assumes a single 10 MHz system clock; all times become cycle counts of it.
`default_nettype none

package hfc_pkg;

  // System clock period in picoseconds (10 MHz)
  localparam int CLK_PERIOD_PS = 100000;
  // Picoseconds per microsecond and per nanosecond
  localparam int PS_PER_US = 1000000;
  localparam int PS_PER_NS = 1000;

  // Width of every latency and start-up counter
  localparam int TIMER_W = 12;

  // Least whole number of cycles covering a time, never below one
  function automatic int cycles_up(input int time_ps);
    int n;
    n = (time_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction

  // Wake-up latencies, in microseconds as characterised
  localparam int APP_IDLE_NORMAL_US = 23;
  localparam int APP_IDLE_CONSTLAT_US = 10;
  localparam int NET_IDLE_NORMAL_US = 15;
  localparam int NET_IDLE_CONSTLAT_US = 7;
  localparam int NET_FORCE_OFF_RELEASE_US = 20;
  localparam int APP_OFF_WAKE_US = 38;
  // Hardware event to interconnect event, in picoseconds (62.5 ns)
  localparam int HW_EVENT_DELAY_PS = 62500;

  // The same latencies as cycle counts
  localparam logic [TIMER_W-1:0] APP_IDLE_NORMAL_CYC =
    TIMER_W'(cycles_up(APP_IDLE_NORMAL_US * PS_PER_US));
  localparam logic [TIMER_W-1:0] APP_IDLE_CONSTLAT_CYC =
    TIMER_W'(cycles_up(APP_IDLE_CONSTLAT_US * PS_PER_US));
  localparam logic [TIMER_W-1:0] NET_IDLE_NORMAL_CYC =
    TIMER_W'(cycles_up(NET_IDLE_NORMAL_US * PS_PER_US));
  localparam logic [TIMER_W-1:0] NET_IDLE_CONSTLAT_CYC =
    TIMER_W'(cycles_up(NET_IDLE_CONSTLAT_US * PS_PER_US));
  localparam logic [TIMER_W-1:0] NET_FORCE_OFF_RELEASE_CYC =
    TIMER_W'(cycles_up(NET_FORCE_OFF_RELEASE_US * PS_PER_US));
  localparam logic [TIMER_W-1:0] APP_OFF_WAKE_CYC =
    TIMER_W'(cycles_up(APP_OFF_WAKE_US * PS_PER_US));
  localparam int HW_EVENT_DELAY_CYC = cycles_up(HW_EVENT_DELAY_PS);

  // Latency timer slots
  localparam int TMR_APP_IDLE = 0;
  localparam int TMR_NET_IDLE = 1;
  localparam int TMR_NET_START = 2;
  localparam int TMR_APP_WAKE = 3;
  localparam int TMR_COUNT = 4;

  // Core indices
  localparam int CORE_APP = 0;
  localparam int CORE_NET = 1;

  // Clock rates in MHz (audio in kHz)
  localparam int SRC_128_MHZ = 128;
  localparam int SRC_64_MHZ = 64;
  localparam int SRC_192_MHZ = 192;
  localparam int APP_CPU_MHZ = 128;
  localparam int NET_CPU_MHZ = 64;
  localparam int FLASH_IF_MHZ = 192;
  localparam int USB_MHZ = 48;
  localparam int PERIPH_HI_MHZ = 64;
  localparam int PERIPH_MID_MHZ = 32;
  localparam int PERIPH_LO_MHZ = 16;
  localparam int AUDIO_LOW_KHZ = 11289;
  localparam int AUDIO_HIGH_KHZ = 12288;

  // Oscillator sequencer states
  typedef enum logic [2:0] {
    OSC_OFF,
    OSC_START,
    OSC_RUN,
    OSC_SWITCH,
    OSC_GATE
  } hfc_osc_state_type;

endpackage

`default_nettype wire

// ### verification/hfc_clock_request_control_sva.sv
// Port checker for the fast clock request controller.
// Assumes one clock domain clk_sys with asynchronous reset rst.
`timescale 1ns/1ns
`default_nettype none

module hfc_clock_request_control_sva #(
  parameter int NUM_CORES = 2,
  parameter int REQS_PER_CORE = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic systemOn,
  input wire logic [NUM_CORES*REQS_PER_CORE-1:0] coreRequests,
  input wire logic [NUM_CORES-1:0] irqEnableShared,
  input wire logic appIdleExit,
  input wire logic appConstLatency,
  input wire logic netCoreForceOff,
  input wire logic [NUM_CORES-1:0] hwEvent,
  input wire logic [NUM_CORES-1:0] coreClockRequest,
  input wire logic [NUM_CORES-1:0] fastClockStartedEvent,
  input wire logic [NUM_CORES-1:0] startedIrq,
  input wire logic fastClockRunning,
  input wire logic fastClockOnCrystal,
  input wire logic appCpuClockEn,
  input wire logic usbClockEn,
  input wire logic appCpuResume,
  input wire logic netCpuStart,
  input wire logic [NUM_CORES-1:0] interconnectEvent
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Idle exit of the app core in normal latency
  sequence appWakeSeq;
    appIdleExit && !appConstLatency;
  endsequence
  // Release of the net core force-off control
  sequence netReleaseSeq;
    $fell(netCoreForceOff);
  endsequence

  req_forward_a: assert property (|coreRequests[REQS_PER_CORE-1:0] |=> coreClockRequest[0])
    else $error("core request not forwarded");
  req_withdraw_a: assert property (!(|coreRequests[REQS_PER_CORE-1:0]) |=> !coreClockRequest[0])
    else $error("core request not withdrawn");
  clock_off_a: assert property (!systemOn [*2] |=> !fastClockRunning && !appCpuClockEn)
    else $error("clock delivered in off state");
  enable_after_run_a: assert property ($rose(appCpuClockEn) |-> fastClockRunning)
    else $error("clock enabled before source runs");
  usb_crystal_a: assert property (usbClockEn |-> fastClockOnCrystal)
    else $error("usb clock without crystal");
  irq_share_a: assert property (startedIrq == (fastClockStartedEvent & $past(irqEnableShared)))
    else $error("started irq not gated by shared enable");
  started_pulse_a: assert property (fastClockStartedEvent[1] |=> !fastClockStartedEvent[1])
    else $error("started event longer than one cycle");
  hw_event_a: assert property (hwEvent[0] |=> interconnectEvent[0])
    else $error("interconnect event late");
  app_resume_a: assert property (appWakeSeq |-> ##[230:231] appCpuResume)
    else $error("app resume latency wrong");
  net_start_a: assert property (netReleaseSeq |-> ##[200:201] netCpuStart)
    else $error("net start latency wrong");
endmodule // hfc_clock_request_control_sva

bind hfc_clock_request_control hfc_clock_request_control_sva #(
  .NUM_CORES(NUM_CORES), .REQS_PER_CORE(REQS_PER_CORE)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .systemOn(systemOn), .coreRequests(coreRequests),
  .irqEnableShared(irqEnableShared), .appIdleExit(appIdleExit),
  .appConstLatency(appConstLatency), .netCoreForceOff(netCoreForceOff), .hwEvent(hwEvent),
  .coreClockRequest(coreClockRequest), .fastClockStartedEvent(fastClockStartedEvent),
  .startedIrq(startedIrq), .fastClockRunning(fastClockRunning),
  .fastClockOnCrystal(fastClockOnCrystal), .appCpuClockEn(appCpuClockEn),
  .usbClockEn(usbClockEn), .appCpuResume(appCpuResume), .netCpuStart(netCpuStart),
  .interconnectEvent(interconnectEvent));

`default_nettype wire

// ### verification/hfc_requester_model.sv
// Model of the clock requesters inside one core.
// Assumes startReq is a one-cycle pulse and clockEn is the core's clock enable.
`timescale 1ns/1ns
`default_nettype none

module hfc_requester_model #(
  parameter int R = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic startReq,
  input wire logic [7:0] holdLen,
  input wire logic clockEn,
  output logic [R-1:0] reqBits
);
  logic [7:0] left; // Clocked cycles still needed
  int slot; // Requester that asks next

  // One requester asks, works while clocked, then goes idle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqBits <= '0;
      left <= 8'h00;
      slot <= 0;
    end else if (startReq) begin
      reqBits <= R'(1) << slot;
      left <= holdLen;
      slot <= (slot + 1) % R;
    end else if (|reqBits && clockEn) begin
      // Counts clocked cycles down, then drops the request
      if (left == 8'h00)
        reqBits <= '0;
      else
        left <= left - 8'h01;
    end
  end
endmodule // hfc_requester_model

`default_nettype wire

// ### verification/test_hfc_clock_request_control.sv
// Self-checking bench for the fast clock request controller.
// Assumes a 10 MHz clk_sys; inputs change on falling edges; short settle counts.
`timescale 1ns/1ns
`default_nettype none

module test_hfc_clock_request_control;
  localparam int R = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic systemOn = 1'b1, keepRunning = 1'b0, appIdleExit = 1'b0, appConstLatency = 1'b0;
  logic netIdleExit = 1'b0, netConstLatency = 1'b0, netCoreForceOff = 1'b1, offWakeup = 1'b0;
  logic go0 = 1'b0, go1 = 1'b0;
  logic [7:0] hold0 = 8'h0A, hold1 = 8'h0A;
  logic [3:0] tree, aud = 4'h0; // App tree enables; audio band, use, stop, start
  logic [1:0] startTask = 2'b00, stopTask = 2'b00, srcSel = 2'b00, irqEn = 2'b00, hwEv = 2'b00;
  logic [R-1:0] req0, req1;
  logic [1:0] coreClockRequest, startedEvt, startedIrq, interconnectEvent;
  logic fastClockRunning, fastClockOnCrystal, internalOscOn, crystalOscOn, appCpuClockEn;
  logic netCpuClockEn, usbClockEn, appCpuResume, netCpuResume, netCpuStart, appCpuStart;
  logic audioClockEn, audioRateHigh;
  int num_errors = 0;
  int n_compared = 0;
  logic [11:0] tExp [6];
  int tPick [6] = '{1, 1, 2, 2, 4, 3};

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  // Requesters of the app core and the net core
  hfc_requester_model #(.R(R)) u_app (.clk_sys(clk_sys), .rst(rst), .startReq(go0),
    .holdLen(hold0), .clockEn(appCpuClockEn), .reqBits(req0));
  hfc_requester_model #(.R(R)) u_net (.clk_sys(clk_sys), .rst(rst), .startReq(go1),
    .holdLen(hold1), .clockEn(netCpuClockEn), .reqBits(req1));

  hfc_clock_request_control #(.NUM_CORES(2), .REQS_PER_CORE(R), .INT_START_CYCLES(2),
    .XO_START_CYCLES(3)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .systemOn(systemOn), .coreRequests({req1, req0}),
    .fastClockStartTask(startTask), .fastClockStopTask(stopTask), .fastSourceSelect(srcSel),
    .keepRunning(keepRunning), .audioStartTask(aud[0]), .audioStopTask(aud[1]),
    .audioInUse(aud[2]), .audioBandHigh(aud[3]), .irqEnableShared(irqEn),
    .appIdleExit(appIdleExit), .appConstLatency(appConstLatency), .netIdleExit(netIdleExit),
    .netConstLatency(netConstLatency), .netCoreForceOff(netCoreForceOff),
    .offWakeup(offWakeup), .hwEvent(hwEv), .coreClockRequest(coreClockRequest),
    .fastClockStartedEvent(startedEvt), .startedIrq(startedIrq),
    .fastClockRunning(fastClockRunning), .fastClockOnCrystal(fastClockOnCrystal),
    .internalOscOn(internalOscOn), .crystalOscOn(crystalOscOn), .appCpuClockEn(appCpuClockEn),
    .netCpuClockEn(netCpuClockEn), .flashIfClockEn(tree[0]), .usbClockEn(usbClockEn),
    .periphClockHiEn(tree[1]), .periphClockMidEn(tree[2]), .periphClockLoEn(tree[3]),
    .audioClockEn(audioClockEn), .audioRateHigh(audioRateHigh), .appCpuResume(appCpuResume),
    .netCpuResume(netCpuResume), .netCpuStart(netCpuStart), .appCpuStart(appCpuStart),
    .interconnectEvent(interconnectEvent));

  // Prints counts and verdict, then ends the run
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one observed value with its expectation
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  // Output watched by a bounded wait
  function automatic logic pick(input int k);
    case (k)
      0: return appCpuClockEn;
      1: return appCpuResume;
      2: return netCpuResume;
      3: return netCpuStart;
      4: return appCpuStart;
      5: return fastClockRunning;
      6: return !internalOscOn;
      7: return netCpuClockEn;
      9: return audioClockEn;
      default: return !crystalOscOn;
    endcase
  endfunction

  // Counts falling edges until the picked output is high
  task automatic await(input int k, input int limit, output logic [11:0] n);
    n = 12'h000;
    while (pick(k) !== 1'b1) begin
      @(negedge clk_sys);
      n = n + 12'h001;
      if (n > limit) begin
        num_errors++;
        $display("mismatch at %0t: wait %0d timed out", $time, k);
        give_verdict();
      end
    end
  endtask

  initial begin
    logic [11:0] n, cEvt, cIrq, cGate;
    tExp = '{hfc_pkg::APP_IDLE_NORMAL_CYC, hfc_pkg::APP_IDLE_CONSTLAT_CYC,
      hfc_pkg::NET_IDLE_NORMAL_CYC, hfc_pkg::NET_IDLE_CONSTLAT_CYC,
      hfc_pkg::APP_OFF_WAKE_CYC, hfc_pkg::NET_FORCE_OFF_RELEASE_CYC};
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check({coreClockRequest, fastClockRunning, internalOscOn, crystalOscOn}, 0, "reset");
    // Automatic request on the internal source
    go0 = 1'b1;
    @(negedge clk_sys);
    go0 = 1'b0;
    await(0, 30, n);
    check(internalOscOn, 1'b1, "internal source on");
    check(fastClockOnCrystal, 1'b0, "source is internal");
    check(coreClockRequest, 2'b01, "core request raised");
    check(netCpuClockEn, 1'b0, "net clock idle");
    check(tree, 4'hF, "app tree on");
    await(6, 60, n);
    check(coreClockRequest, 2'b00, "core request withdrawn");
    check(fastClockRunning, 1'b0, "tree stopped");
    $display("test request done");
    // Kept running, then off state blocks the net core clock
    keepRunning = 1'b1;
    await(5, 30, n);
    check(coreClockRequest, 2'b00, "runs without request");
    hold1 = 8'h40;
    go1 = 1'b1;
    @(negedge clk_sys);
    go1 = 1'b0;
    await(7, 30, n);
    check(appCpuClockEn, 1'b0, "app clock idle");
    systemOn = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({fastClockRunning, netCpuClockEn}, 2'b00, "off state");
    systemOn = 1'b1;
    await(7, 30, n);
    keepRunning = 1'b0;
    await(6, 200, n);
    $display("test keep and off done");
    // Crystal start with retrigger while the app core runs
    hold0 = 8'h50;
    go0 = 1'b1;
    @(negedge clk_sys);
    go0 = 1'b0;
    await(0, 30, n);
    srcSel = 2'b10;
    irqEn = 2'b10;
    startTask = 2'b10;
    @(negedge clk_sys);
    startTask = 2'b00;
    @(negedge clk_sys);
    startTask = 2'b10;
    @(negedge clk_sys);
    startTask = 2'b00;
    cEvt = 12'h000;
    cIrq = 12'h000;
    cGate = 12'h000;
    repeat (40) begin
      @(negedge clk_sys);
      cEvt = cEvt + 12'(startedEvt[1]);
      cIrq = cIrq + 12'(startedIrq[1]);
      cGate = cGate + 12'(!appCpuClockEn);
    end
    check(cEvt, 12'h001, "one started event");
    check(cIrq, 12'h001, "started irq");
    check(cGate, 12'h001, "gate during switch");
    check(fastClockOnCrystal, 1'b1, "crystal selected");
    check(usbClockEn, 1'b1, "usb clock on crystal");
    srcSel = 2'b11;
    startTask = 2'b01;
    @(negedge clk_sys);
    startTask = 2'b00;
    stopTask = 2'b10;
    @(negedge clk_sys);
    stopTask = 2'b00;
    repeat (100) @(negedge clk_sys);
    check(crystalOscOn, 1'b1, "held by other core");
    stopTask = 2'b01;
    @(negedge clk_sys);
    stopTask = 2'b00;
    await(8, 60, n);
    // Audio held by its use after its stop
    aud = 4'hD;
    @(negedge clk_sys);
    aud = 4'hE;
    @(negedge clk_sys);
    aud = 4'hC;
    await(9, 30, n);
    check({audioRateHigh, fastClockOnCrystal}, 2'b11, "audio on crystal");
    aud = 4'h8;
    await(8, 60, n);
    $display("test crystal done");
    // Hardware event and wake-up latencies
    hwEv = 2'b01;
    @(negedge clk_sys);
    hwEv = 2'b00;
    check(interconnectEvent, 2'b01, "interconnect event");
    for (int i = 0; i < 6; i++) begin
      appConstLatency = (i == 1);
      netConstLatency = (i == 3);
      appIdleExit = (i < 2);
      netIdleExit = (i == 2 || i == 3);
      offWakeup = (i == 4);
      netCoreForceOff = (i != 5);
      @(negedge clk_sys);
      {appIdleExit, netIdleExit, offWakeup} = 3'b000;
      await(tPick[i], 500, n);
      check(n, tExp[i], "wake latency");
      repeat (3) @(negedge clk_sys);
    end
    $display("test latency done");
    give_verdict();
  end
endmodule // test_hfc_clock_request_control

`default_nettype wire
